/* File: core/tgs_byte_if.sv */
// byte level carrier between serial shifter and command decoder
`timescale 1ns/1ps
interface tgs_byte_if;
   logic       rxStrobe;
   logic [7:0] rxByte;
   logic       frameActive;
   logic       loadReply;
   logic [7:0] replyByte;

   modport shifter (output rxStrobe, output rxByte, output frameActive,
                    input loadReply, input replyByte);
   modport decoder (input rxStrobe, input rxByte, input frameActive,
                    output loadReply, output replyByte);
endinterface

/* File: core/tgs_pkg.sv */
// shared constants and types of the tone generator status bank
package tgs_pkg;
   // ------------------------------------------------------------
   // command codes
   // ------------------------------------------------------------
   localparam logic [7:0] CMD_GENERAL_RESET = 8'h01;
   localparam logic [7:0] CMD_WRITE_CONTROL = 8'h30;
   localparam logic [7:0] CMD_READ_STATUS   = 8'h31;
   localparam logic [7:0] CMD_WRITE_NOTONE  = 8'h33;
   localparam logic [7:0] CMD_TONE_ONE      = 8'h34;
   localparam logic [7:0] CMD_TONE_TWO      = 8'h35;
   localparam logic [7:0] CMD_WRITE_GPTIMER = 8'h36;

   // ------------------------------------------------------------
   // field layouts
   // ------------------------------------------------------------
   localparam int BYTE_W       = 8;
   localparam int WORD_W       = 16;
   localparam int FREQ_W       = 13;
   localparam int BIT_BIAS     = 13;
   localparam int BIT_SQUARE   = 14;
   localparam int CTL_GP_IE    = 6;
   localparam int CTL_DEC_IE   = 5;
   localparam int ST_MEASURE   = 0;
   localparam int ST_NOTONE    = 1;
   localparam int ST_GPTIMER   = 2;
   localparam int ST_LOGIC_IN  = 3;
   localparam int BIT_CNT_W    = 3;
   localparam logic [BIT_CNT_W-1:0] LAST_BIT = 3'h7;

   localparam logic [WORD_W-1:0] TONE_RESET = 16'h0000;
   localparam logic [FREQ_W-1:0] FREQ_ZERO  = 13'h0000;
   localparam logic [2:0]        FLAGS_RESET = 3'h0;
   localparam logic [1:0]        ENABLES_RESET = 2'h0;

   // ------------------------------------------------------------
   // frame states and output forms
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      FR_COMMAND = 2'b00,
      FR_DATA_HI = 2'b01,
      FR_DATA_LO = 2'b10,
      FR_IGNORE  = 2'b11
   } tgs_frame_t;

   typedef enum logic [1:0] {
      CUE_NEG_SUPPLY = 2'b00,
      CUE_BIAS       = 2'b01,
      CUE_SQUARE     = 2'b10,
      CUE_SINE       = 2'b11
   } tgs_cue_t;
endpackage

/* File: core/tgs_serial_shifter.sv */
// serial command bus shifter: bytes in and reply out, msb first
`timescale 1ns/1ps
module tgs_serial_shifter
   import tgs_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       busSelect_n,
   input  wire logic       busClk,
   input  wire logic       cmdData,
   output      logic       replyData,
   tgs_byte_if.shifter     bus
);
   logic                 busClk_q;
   logic [BIT_CNT_W-1:0] bitCnt_q;
   logic [7:0]           rxShift_q;
   logic [7:0]           txShift_q;
   logic                 rise;
   logic                 fall;

   assign rise = busClk & ~busClk_q & ~busSelect_n;
   assign fall = ~busClk & busClk_q & ~busSelect_n;
   assign bus.frameActive = ~busSelect_n;
   assign bus.rxByte = rxShift_q;
   assign replyData = txShift_q[BYTE_W-1];

   always_ff @(posedge sys_clk) begin
      if (rst) busClk_q <= 1'b0;
      else     busClk_q <= busClk;
   end

   // ------------------------------------------------------------
   // receive: sample on rising clock, msb first
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst || busSelect_n) begin
         bitCnt_q     <= '0;
         rxShift_q    <= 8'h00;
         bus.rxStrobe <= 1'b0;
      end else begin
         bus.rxStrobe <= rise && (bitCnt_q == LAST_BIT);
         if (rise) begin
            rxShift_q <= {rxShift_q[BYTE_W-2:0], cmdData};
            bitCnt_q  <= bitCnt_q + 3'h1;
         end
      end
   end

   // ------------------------------------------------------------
   // reply: change on falling clock, msb first
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst)                txShift_q <= 8'h00;
      else if (bus.loadReply) txShift_q <= bus.replyByte;
      else if (fall)          txShift_q <= {txShift_q[BYTE_W-2:0], 1'b0};
   end
endmodule // tgs_serial_shifter

/* File: core/tone_gen_status_registers.sv */
// status flags and tone generator command registers behind the serial bus
// How it works
// - interrupt line reports enabled status flags
// - flags set regardless of interrupt enables
// - bit2 timer flag; clears read/write/reset
// - bit1 no-tone flag; clears read/write/reset
// - bit0 set on measurement complete
// - bit0 clears only on read/reset
// - timer interrupts need matching enable
// - code 34 writes tone one word
// - code 35 writes tone two word
// - bit 13 holds output at bias
// - tone two bit 14: square/sine
// - tone two powersave drives negative supply
// - both powersaved: summing amplifier powersaved
// - code 31 answers one status byte
// - decoder enable gates bits 1,0; transmit bit 2
`timescale 1ns/1ps
module tone_gen_status_registers
   import tgs_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              rst,
   input  wire logic              busSelect_n,
   input  wire logic              busClk,
   input  wire logic              cmdData,
   output      logic              replyData,
   output      logic              irq_n,
   input  wire logic              gpTimerExpired,
   input  wire logic              notoneExpired,
   input  wire logic              measureDone,
   input  wire logic              logicInput,
   output      logic              generalReset,
   output      logic              notoneWrite,
   output      logic              gpTimerWrite,
   output      logic [7:0]        controlByte,
   output      logic [FREQ_W-1:0] toneOneFreq,
   output      logic              toneOneBiasHold,
   output      logic              toneOnePowersave,
   output      logic [FREQ_W-1:0] toneTwoFreq,
   output      logic              toneTwoBiasHold,
   output      logic              toneTwoPowersave,
   output      tgs_cue_t          calibrationCueOutput,
   output      logic              summingPowersave
);
   tgs_byte_if  bif ();

   tgs_frame_t  frame_q;
   logic [7:0]  cmd_q;
   logic [7:0]  dataHi_q;
   logic [WORD_W-1:0] toneOne_q;
   logic [WORD_W-1:0] toneTwo_q;
   logic [2:0]  flags_q;
   logic [1:0]  enables_q;
   logic        cmdStrobe;
   logic        wordStrobe;
   logic        statusRead;
   logic [7:0]  statusByte;
   logic [2:0]  flagSet;
   logic [2:0]  flagClear;
   logic        timerIrq;
   logic        decoderIrq;

   function automatic logic isPowersave(input logic [WORD_W-1:0] w);
      return w[FREQ_W-1:0] == FREQ_ZERO;
   endfunction

   // ------------------------------------------------------------
   // serial shifter and its byte carrier
   // ------------------------------------------------------------
   tgs_serial_shifter u_shifter (
      .sys_clk     (sys_clk),
      .rst         (rst),
      .busSelect_n (busSelect_n),
      .busClk      (busClk),
      .cmdData     (cmdData),
      .replyData   (replyData),
      .bus         (bif.shifter)
   );

   // ------------------------------------------------------------
   // frame decode
   // ------------------------------------------------------------
   assign cmdStrobe  = bif.rxStrobe && frame_q == FR_COMMAND;
   assign wordStrobe = bif.rxStrobe && frame_q == FR_DATA_LO;
   assign statusRead = cmdStrobe && bif.rxByte == CMD_READ_STATUS;
   assign bif.loadReply = statusRead;
   assign bif.replyByte = statusByte;

   always_ff @(posedge sys_clk) begin
      if (rst || !bif.frameActive) begin
         frame_q <= FR_COMMAND;
      end else if (bif.rxStrobe) begin
         case (frame_q)
            FR_COMMAND: begin
               if (bif.rxByte == CMD_TONE_ONE || bif.rxByte == CMD_TONE_TWO)
                  frame_q <= FR_DATA_HI;
               else
                  frame_q <= FR_IGNORE;
            end
            FR_DATA_HI: frame_q <= FR_DATA_LO;
            FR_DATA_LO: frame_q <= FR_IGNORE;
            FR_IGNORE:  frame_q <= FR_IGNORE;
            default:    frame_q <= FR_COMMAND;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cmd_q    <= 8'h00;
         dataHi_q <= 8'h00;
      end else if (cmdStrobe) begin
         cmd_q <= bif.rxByte;
      end else if (bif.rxStrobe && frame_q == FR_DATA_HI) begin
         dataHi_q <= bif.rxByte;
      end
   end

   // ------------------------------------------------------------
   // strobes toward the rest of the device
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         generalReset <= 1'b0;
         notoneWrite  <= 1'b0;
         gpTimerWrite <= 1'b0;
      end else begin
         generalReset <= cmdStrobe && bif.rxByte == CMD_GENERAL_RESET;
         notoneWrite  <= bif.rxStrobe && frame_q == FR_IGNORE
                         && cmd_q == CMD_WRITE_NOTONE;
         gpTimerWrite <= bif.rxStrobe && frame_q == FR_IGNORE
                         && cmd_q == CMD_WRITE_GPTIMER;
      end
   end

   // ------------------------------------------------------------
   // control byte: every data byte after its command loads it, last one kept
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst || generalReset) begin
         controlByte <= 8'h00;
         enables_q   <= ENABLES_RESET;
      end else if (bif.rxStrobe && frame_q == FR_IGNORE && cmd_q == CMD_WRITE_CONTROL) begin
         controlByte <= bif.rxByte;
         enables_q   <= {bif.rxByte[CTL_GP_IE], bif.rxByte[CTL_DEC_IE]};
      end
   end

   // ------------------------------------------------------------
   // tone generator command words
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst || generalReset) begin
         toneOne_q <= TONE_RESET;
         toneTwo_q <= TONE_RESET;
      end else if (wordStrobe) begin
         if (cmd_q == CMD_TONE_ONE) toneOne_q <= {dataHi_q, bif.rxByte};
         if (cmd_q == CMD_TONE_TWO) toneTwo_q <= {dataHi_q, bif.rxByte};
      end
   end

   // ------------------------------------------------------------
   // generator frequency, bias hold and powersave decode
   // ------------------------------------------------------------
   assign toneOneFreq      = toneOne_q[FREQ_W-1:0];
   assign toneTwoFreq      = toneTwo_q[FREQ_W-1:0];
   assign toneOneBiasHold  = toneOne_q[BIT_BIAS];
   assign toneTwoBiasHold  = toneTwo_q[BIT_BIAS];
   assign toneOnePowersave = isPowersave(toneOne_q);
   assign toneTwoPowersave = isPowersave(toneTwo_q);
   assign summingPowersave = toneOnePowersave && toneTwoPowersave;

   // ------------------------------------------------------------
   // calibration/cue output form, powersave first
   // ------------------------------------------------------------
   always_comb begin
      if (toneTwoPowersave)
         calibrationCueOutput = CUE_NEG_SUPPLY;
      else if (toneTwo_q[BIT_BIAS])
         calibrationCueOutput = CUE_BIAS;
      else if (toneTwo_q[BIT_SQUARE])
         calibrationCueOutput = CUE_SQUARE;
      else
         calibrationCueOutput = CUE_SINE;
   end

   // ------------------------------------------------------------
   // status flags: set wins over clear
   // ------------------------------------------------------------
   assign flagSet[ST_GPTIMER]   = gpTimerExpired;
   assign flagSet[ST_NOTONE]    = notoneExpired;
   assign flagSet[ST_MEASURE]   = measureDone;
   assign flagClear[ST_GPTIMER] = statusRead || gpTimerWrite || generalReset;
   assign flagClear[ST_NOTONE]  = statusRead || notoneWrite || generalReset;
   assign flagClear[ST_MEASURE] = statusRead || generalReset;

   for (genvar f = 0; f < $bits(flags_q); f++) begin : g_flag
      always_ff @(posedge sys_clk) begin
         if (rst) begin
            flags_q[f] <= FLAGS_RESET[f];
         end else if (flagSet[f]) begin
            flags_q[f] <= 1'b1;
         end else if (flagClear[f]) begin
            flags_q[f] <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // status reply byte
   // ------------------------------------------------------------
   assign statusByte = {4'h0, logicInput, flags_q};

   // ------------------------------------------------------------
   // interrupt request: transmit enable high bit, decoder low bit
   // ------------------------------------------------------------
   assign timerIrq   = flags_q[ST_GPTIMER] && enables_q[1];
   assign decoderIrq = (flags_q[ST_NOTONE] || flags_q[ST_MEASURE]) && enables_q[0];
   assign irq_n      = !(timerIrq || decoderIrq);
endmodule // tone_gen_status_registers

/* File: testbench/tgs_host_model.sv */
// host side of the serial command bus
`timescale 1ns/1ps
module tgs_host_model (
   input  wire logic sys_clk,
   output      logic busSelect_n,
   output      logic busClk,
   output      logic cmdData,
   input  wire logic replyData
);
   initial begin
      busSelect_n = 1'b1;
      busClk      = 1'b0;
      cmdData     = 1'b1;
   end

   // command byte then nBytes data bytes; reply shifted in just before each later fall
   task automatic frame(input logic [7:0] cmd, input int nBytes, input logic [15:0] data,
                        output logic [7:0] reply);
      logic [31:0] bits;
      bits  = {cmd, data, 8'h00};
      reply = 8'h00;
      @(negedge sys_clk);
      busSelect_n = 1'b0;
      repeat (2) @(negedge sys_clk);
      for (int i = 0; i < 8 * (nBytes + 1); i++) begin
         // reply bit stands until the next fall: take it before lowering
         if (i >= 8) reply = {reply[6:0], replyData};
         busClk  = 1'b0;
         cmdData = bits[31-i];
         repeat (4) @(negedge sys_clk);
         busClk = 1'b1;
         repeat (4) @(negedge sys_clk);
      end
      busClk = 1'b0;
      repeat (2) @(negedge sys_clk);
      busSelect_n = 1'b1;
      cmdData     = ~cmdData;
      repeat (4) @(negedge sys_clk);
   endtask
endmodule // tgs_host_model

/* File: testbench/tgs_props.sv */
// concurrent checks on the tone command and status bank
`timescale 1ns/1ps
module tgs_props
   import tgs_pkg::*;
(
   input wire logic              sys_clk,
   input wire logic              rst,
   input wire logic              irq_n,
   input wire logic              gpTimerExpired,
   input wire logic              notoneExpired,
   input wire logic              measureDone,
   input wire logic              generalReset,
   input wire logic [7:0]        controlByte,
   input wire logic              toneOnePowersave,
   input wire logic [FREQ_W-1:0] toneTwoFreq,
   input wire logic              toneTwoBiasHold,
   input wire logic              toneTwoPowersave,
   input wire tgs_cue_t          calibrationCueOutput,
   input wire logic              summingPowersave
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   // ---------------------------------------------
   // sequences
   // ---------------------------------------------
   sequence s_cleared;
      controlByte == 8'h00 && toneTwoPowersave && irq_n;
   endsequence

   // ---------------------------------------------
   // assertions
   // ---------------------------------------------
   a_irq_timer: assert property (gpTimerExpired && controlByte[CTL_GP_IE] && !generalReset
      |=> !irq_n) else $error("timer irq missing");
   a_irq_decoder: assert property ((notoneExpired || measureDone) && !generalReset
      && controlByte[CTL_DEC_IE] |=> !irq_n) else $error("decoder irq missing");
   a_irq_quiet: assert property (controlByte[6:5] == 2'b00 |-> irq_n)
      else $error("irq without enable");
   a_two_powersave: assert property (toneTwoPowersave == (toneTwoFreq == FREQ_ZERO))
      else $error("tone two powersave wrong");
   a_cue_negative: assert property (toneTwoPowersave |-> calibrationCueOutput == CUE_NEG_SUPPLY)
      else $error("cue not at negative supply");
   a_cue_bias: assert property (!toneTwoPowersave && toneTwoBiasHold
      |-> calibrationCueOutput == CUE_BIAS) else $error("cue not at bias");
   a_sum_powersave: assert property (summingPowersave == (toneOnePowersave && toneTwoPowersave))
      else $error("summing powersave wrong");
   a_reset_clears: assert property (generalReset |-> ##[1:2] s_cleared)
      else $error("general reset did not clear");
endmodule // tgs_props

bind tone_gen_status_registers tgs_props i_tgs_props (
   .sys_clk(sys_clk), .rst(rst), .irq_n(irq_n), .gpTimerExpired(gpTimerExpired),
   .notoneExpired(notoneExpired), .measureDone(measureDone), .generalReset(generalReset),
   .controlByte(controlByte), .toneOnePowersave(toneOnePowersave), .toneTwoFreq(toneTwoFreq),
   .toneTwoBiasHold(toneTwoBiasHold), .toneTwoPowersave(toneTwoPowersave),
   .calibrationCueOutput(calibrationCueOutput), .summingPowersave(summingPowersave)
);

/* File: testbench/tone_gen_status_registers_tb.sv */
// self-checking bench for the tone command and status bank
`timescale 1ns/1ps
module tone_gen_status_registers_tb
   import tgs_pkg::*;
;
   logic              sys_clk, rst, busSelect_n, busClk, cmdData, replyData, irq_n, logicInput;
   logic              gpTimerExpired, notoneExpired, measureDone, generalReset, notoneWrite;
   logic              gpTimerWrite, toneOneBiasHold, toneTwoBiasHold, toneOnePowersave;
   logic              toneTwoPowersave, summingPowersave;
   logic [7:0]        controlByte, rep;
   logic [FREQ_W-1:0] toneOneFreq, toneTwoFreq;
   tgs_cue_t          calibrationCueOutput;
   int                failCount = 0;
   int                checks = 0;
   int                resetPulses = 0;
   int                notonePulses = 0;
   int                gpPulses = 0;

   tone_gen_status_registers i_tone_gen_status_registers (
      .sys_clk(sys_clk), .rst(rst), .busSelect_n(busSelect_n), .busClk(busClk),
      .cmdData(cmdData), .replyData(replyData), .irq_n(irq_n), .gpTimerExpired(gpTimerExpired),
      .notoneExpired(notoneExpired), .measureDone(measureDone), .logicInput(logicInput),
      .generalReset(generalReset), .notoneWrite(notoneWrite), .gpTimerWrite(gpTimerWrite),
      .controlByte(controlByte), .toneOneFreq(toneOneFreq), .toneOneBiasHold(toneOneBiasHold),
      .toneOnePowersave(toneOnePowersave), .toneTwoFreq(toneTwoFreq),
      .toneTwoBiasHold(toneTwoBiasHold), .toneTwoPowersave(toneTwoPowersave),
      .calibrationCueOutput(calibrationCueOutput), .summingPowersave(summingPowersave)
   );
   tgs_host_model i_tgs_host_model (.sys_clk(sys_clk), .busSelect_n(busSelect_n),
      .busClk(busClk), .cmdData(cmdData), .replyData(replyData));

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // one-cycle strobes counted mid-cycle, away from their launching edge
   always @(negedge sys_clk) begin
      if (generalReset) resetPulses++;
      if (notoneWrite) notonePulses++;
      if (gpTimerWrite) gpPulses++;
   end

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
         failCount++;
      end
   endtask
   task automatic evt(input logic [2:0] e);
      {gpTimerExpired, notoneExpired, measureDone} = e;
      @(negedge sys_clk);
      {gpTimerExpired, notoneExpired, measureDone} = 3'h0;
      repeat (2) @(negedge sys_clk);
   endtask
   task automatic wr(input logic [7:0] cmd, input int nb, input logic [15:0] d);
      i_tgs_host_model.frame(cmd, nb, d, rep);
   endtask

   task automatic t_tones();
      logic [15:0] w2 [4] = '{16'h4123, 16'h0123, 16'h2123, 16'h0000};
      tgs_cue_t    cue [4] = '{CUE_SQUARE, CUE_SINE, CUE_BIAS, CUE_NEG_SUPPLY};
      wr(CMD_TONE_ONE, 2, 16'h2ABC);
      chk("toneOneFreq", 16'h0ABC, {3'h0, toneOneFreq});
      chk("toneOneBiasHold", 16'h0001, {15'h0, toneOneBiasHold});
      chk("toneOnePowersave", 16'h0000, {15'h0, toneOnePowersave});
      wr(CMD_TONE_ONE, 1, 16'h0000);
      chk("toneOneFreq kept", 16'h0ABC, {3'h0, toneOneFreq});
      wr(CMD_TONE_ONE, 2, 16'h0000);
      chk("toneOnePowersave zero", 16'h0001, {15'h0, toneOnePowersave});
      for (int i = 0; i < 4; i++) begin
         wr(CMD_TONE_TWO, 2, w2[i]);
         chk("toneTwoFreq", {3'h0, w2[i][12:0]}, {3'h0, toneTwoFreq});
         chk("toneTwoBiasHold", {15'h0, w2[i][13]}, {15'h0, toneTwoBiasHold});
         chk("cue", {14'h0, cue[i]}, {14'h0, calibrationCueOutput});
         chk("toneTwoPowersave", {15'h0, i == 3}, {15'h0, toneTwoPowersave});
         chk("summingPowersave", {15'h0, i == 3}, {15'h0, summingPowersave});
      end
   endtask

   task automatic t_status();
      logicInput = 1'b1;
      evt(3'b111);
      chk("irq_n disabled", 16'h0001, {15'h0, irq_n});
      wr(CMD_READ_STATUS, 1, 16'h0000);
      chk("status", 16'h000F, {8'h0, rep});
      logicInput = 1'b0;
      wr(CMD_READ_STATUS, 1, 16'h0000);
      chk("status read clear", 16'h0000, {8'h0, rep});
   endtask

   task automatic t_irq();
      wr(CMD_WRITE_CONTROL, 1, 16'h4000);
      evt(3'b010);
      chk("irq_n notone gated", 16'h0001, {15'h0, irq_n});
      evt(3'b100);
      chk("irq_n timer", 16'h0000, {15'h0, irq_n});
      wr(CMD_WRITE_GPTIMER, 1, 16'h0500);
      chk("irq_n timer write", 16'h0001, {15'h0, irq_n});
      chk("gpTimerWrite pulses", 16'h0001, 16'(gpPulses));
      wr(CMD_WRITE_CONTROL, 1, 16'h2000);
      chk("irq_n notone", 16'h0000, {15'h0, irq_n});
      wr(CMD_WRITE_NOTONE, 1, 16'h0100);
      chk("irq_n notone write", 16'h0001, {15'h0, irq_n});
      chk("notoneWrite pulses", 16'h0001, 16'(notonePulses));
      evt(3'b001);
      wr(CMD_WRITE_NOTONE, 1, 16'h0200);
      chk("irq_n measure held", 16'h0000, {15'h0, irq_n});
      chk("notoneWrite pulses again", 16'h0002, 16'(notonePulses));
      wr(CMD_GENERAL_RESET, 0, 16'h0000);
      chk("generalReset pulses", 16'h0001, 16'(resetPulses));
      chk("controlByte reset", 16'h0000, {8'h0, controlByte});
      wr(CMD_READ_STATUS, 1, 16'h0000);
      chk("status after reset", 16'h0000, {8'h0, rep});
   endtask

   task automatic finish_test();
      if (failCount == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      {rst, gpTimerExpired, notoneExpired, measureDone, logicInput} = 5'b10000;
      repeat (20) @(negedge sys_clk);
      rst = 1'b0;
      t_tones();
      t_status();
      t_irq();
      finish_test();
   end

   // watchdog well beyond the few thousand cycles the scenarios need
   initial begin
      #1_000_000;
      failCount++;
      finish_test();
   end
endmodule // tone_gen_status_registers_tb
